// File: wqas_regs.svh
// Constants for the write-queue address select block
// Operation
// RULE1: The write address bus is five bits wide and serves both queue selection and flag-bus device selection.
// RULE2: The two low address bits pick one of four queues inside the device.
// RULE3: The three high address bits are a device number picking one of up to eight expanded devices.
// RULE4: A queue selection takes effect here only when the high three bits equal this device's identity.
// RULE5: A new queue address is captured on a rising edge only while the address strobe is high.
// RULE6: On the capturing edge and the next edge, enabled writes still go to the old queue.
// RULE7: From the second edge after a selection, enabled writes go to the new queue.
// RULE8: In strobed flag mode the high three bits choose which device drives the almost-full flag bus.
// RULE9: The two low address bits are ignored during a flag-bus device selection.
// RULE10: The flag-bus device is captured on an edge with the flag strobe high, while writes to the old queue continue.
// RULE11: The controller never raises both strobes in one cycle and never holds the address strobe high forever.
// RULE12: The controller makes no queue selection before programming is done, shown by the done output going low; the model selects anyway after 64 clocks.
// RULE13: Queue selection does not depend on the active-low write enable, which only gates storing.
// RULE14: A captured queue address for another device deselects the local write port.
`ifndef WQAS_REGS_SVH
`define WQAS_REGS_SVH

`define WQAS_ADDR_W      5
`define WQAS_QSEL_W      2
`define WQAS_DEV_W       3
`define WQAS_QUEUES      4
`define WQAS_QSEL_LSB    0
`define WQAS_DEV_LSB     2
`define WQAS_RST_QUEUE   2'h0
`define WQAS_RST_DEV     3'h0
`define WQAS_SWITCH_EDGES 2
`define WQAS_STRAP_WAIT  2'h2

`endif

// File: wqas_pkg.sv
// Types shared by the write-queue address select block
package wqas_pkg;
  typedef logic [1:0] wqas_queue_t;
  typedef logic [2:0] wqas_dev_t;
  typedef logic [3:0] wqas_onehot_t;
  typedef enum logic
  {
    WQAS_PIPE_IDLE   = 1'b0,
    WQAS_PIPE_SWITCH = 1'b1
  } wqas_pipe_t;
endpackage : wqas_pkg

// File: wqas_sel_if.sv
// Carrier between address decode and the queue switch pipeline
`timescale 1ns/10ps
`default_nettype none
interface wqas_sel_if;
  logic                 ce;
  logic                 cap;
  wqas_pkg::wqas_queue_t cap_queue;
  logic                 cap_match;
  wqas_pkg::wqas_queue_t act_queue;
  logic                 act_sel;
  modport ctl  (output ce, output cap, output cap_queue, output cap_match,
                input act_queue, input act_sel);
  modport pipe (input ce, input cap, input cap_queue, input cap_match,
                output act_queue, output act_sel);
endinterface : wqas_sel_if
`default_nettype wire

// File: wqas_sel_pipe.sv
// Two-edge queue switch pipeline
`timescale 1ns/10ps
`default_nettype none
`include "wqas_regs.svh"
module wqas_sel_pipe
(
  input  wire logic     clock,
  input  wire logic     nrst,
  wqas_sel_if.pipe      sel
);
  wqas_pkg::wqas_pipe_t  state_r;
  wqas_pkg::wqas_queue_t pend_queue_r;
  logic                  pend_match_r;
  wqas_pkg::wqas_queue_t act_queue_r;
  logic                  act_sel_r;

  // Capture edge loads pending; next edge moves it to active
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_queue_r <= `WQAS_RST_QUEUE;
      pend_match_r <= 1'b0;
    end
    else if (sel.ce && sel.cap)
    begin
      pend_queue_r <= sel.cap_queue; // RULE5
      pend_match_r <= sel.cap_match; // RULE4
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_r <= wqas_pkg::WQAS_PIPE_IDLE;
    else if (sel.ce)
      state_r <= sel.cap ? wqas_pkg::WQAS_PIPE_SWITCH : wqas_pkg::WQAS_PIPE_IDLE;
  end

  // No queue is selected until the first selection after reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      act_queue_r <= `WQAS_RST_QUEUE;
      act_sel_r   <= 1'b0;
    end
    else if (sel.ce)
    begin
      case (state_r)
        wqas_pkg::WQAS_PIPE_SWITCH:
        begin
          act_queue_r <= pend_queue_r; // RULE6 RULE7
          act_sel_r   <= pend_match_r; // RULE14
        end
        default:
        begin
          act_queue_r <= act_queue_r;
          act_sel_r   <= act_sel_r;
        end
      endcase
    end
  end

  assign sel.act_queue = act_queue_r;
  assign sel.act_sel   = act_sel_r;
endmodule : wqas_sel_pipe
`default_nettype wire

// File: wqas_write_addr_select.sv
// Write-port queue and flag-bus device selection
`timescale 1ns/10ps
`default_nettype none
`include "wqas_regs.svh"
module wqas_write_addr_select
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  input  wire logic [`WQAS_ADDR_W-1:0]  write_queue_addr,
  input  wire logic                     write_addr_strobe,
  input  wire logic                     flag_device_strobe,
  input  wire logic                     write_en_n,
  input  wire logic [`WQAS_DEV_W-1:0]   device_id,
  input  wire logic [`WQAS_QUEUES-1:0]  queue_almost_full,
  output logic      [`WQAS_QUEUES-1:0]  queue_write,
  output logic      [`WQAS_QSEL_W-1:0]  active_queue,
  output logic                          write_port_selected,
  output logic      [`WQAS_DEV_W-1:0]   flag_device_sel,
  output logic      [`WQAS_QUEUES-1:0]  almost_full_flag_bus_o,
  output logic                          almost_full_flag_bus_oe
);
  localparam int SYNC_W = `WQAS_ADDR_W + 3 + `WQAS_DEV_W;

  logic [SYNC_W-1:0]         sync1_r;
  logic [SYNC_W-1:0]         sync2_r;
  wqas_pkg::wqas_dev_t       own_id_r;
  logic                      id_taken_r;
  logic [1:0]                id_wait_r;
  logic [`WQAS_ADDR_W-1:0]   addr_s;
  logic                      wstb_s;
  logic                      fstb_s;
  logic                      wen_n_s;
  wqas_pkg::wqas_dev_t       id_s;
  wqas_pkg::wqas_dev_t       addr_dev;
  logic                      wr_go;
  wqas_pkg::wqas_onehot_t    queue_write_r;
  wqas_pkg::wqas_dev_t       flag_dev_r;
  logic                      flag_drive_r;
  wqas_pkg::wqas_onehot_t    flag_bus_r;

  wqas_sel_if sel ();

  function automatic wqas_pkg::wqas_onehot_t queue_onehot(input wqas_pkg::wqas_queue_t q);
    queue_onehot = wqas_pkg::wqas_onehot_t'(4'h1 << q);
  endfunction : queue_onehot

  function automatic logic id_match(input wqas_pkg::wqas_dev_t a, input wqas_pkg::wqas_dev_t b);
    id_match = (a == b);
  endfunction : id_match

  // Address, strobe, write-enable and identity pins pass two flops before use; queue_almost_full passes one
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else if (clk_en)
    begin
      sync1_r <= {device_id, write_en_n, flag_device_strobe, write_addr_strobe,
                  write_queue_addr};
      sync2_r <= sync1_r;
    end
  end

  assign addr_s  = sync2_r[`WQAS_ADDR_W-1:0];
  assign wstb_s  = sync2_r[`WQAS_ADDR_W];
  assign fstb_s  = sync2_r[`WQAS_ADDR_W+1];
  assign wen_n_s = sync2_r[`WQAS_ADDR_W+2];
  assign id_s    = sync2_r[SYNC_W-1:`WQAS_ADDR_W+3];
  assign addr_dev = addr_s[`WQAS_DEV_LSB +: `WQAS_DEV_W]; // RULE1 RULE3

  // Identity strap is caught once, when the synchroniser holds the pin, not its reset value
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      own_id_r   <= `WQAS_RST_DEV;
      id_taken_r <= 1'b0;
      id_wait_r  <= 2'h0;
    end
    else if (clk_en && !id_taken_r)
    begin
      if (id_wait_r == `WQAS_STRAP_WAIT)
      begin
        own_id_r   <= id_s;
        id_taken_r <= 1'b1;
      end
      else
        id_wait_r <= id_wait_r + 2'h1;
    end
  end

  // Queue capture ignores the write enable entirely
  assign sel.ce        = clk_en;
  assign sel.cap       = wstb_s; // RULE5 RULE13
  assign sel.cap_queue = addr_s[`WQAS_QSEL_LSB +: `WQAS_QSEL_W]; // RULE2
  assign sel.cap_match = id_match(addr_dev, own_id_r); // RULE4 RULE14

  wqas_sel_pipe u_pipe
  (
    .clock (clock),
    .nrst  (nrst),
    .sel   (sel)
  );

  // Enable only gates storing into the active queue
  assign wr_go = !wen_n_s && sel.act_sel; // RULE13 RULE14

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      queue_write_r <= '0;
    else if (clk_en)
      queue_write_r <= wr_go ? queue_onehot(sel.act_queue) : '0; // RULE6 RULE7 RULE10
  end

  // Flag-bus device selection uses only the high address bits
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      flag_dev_r   <= `WQAS_RST_DEV;
      flag_drive_r <= 1'b0;
    end
    else if (clk_en && fstb_s)
    begin
      flag_dev_r   <= addr_dev; // RULE8 RULE9 RULE10
      flag_drive_r <= id_match(addr_dev, own_id_r); // RULE8
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flag_bus_r <= '0;
    else if (clk_en)
      flag_bus_r <= queue_almost_full;
  end

  assign queue_write             = queue_write_r;
  assign active_queue            = sel.act_queue;
  assign write_port_selected     = sel.act_sel;
  assign flag_device_sel         = flag_dev_r;
  assign almost_full_flag_bus_o  = flag_drive_r ? flag_bus_r : '0;
  assign almost_full_flag_bus_oe = flag_drive_r;

  sequence s_sel_cap;
    clk_en && wstb_s;
  endsequence

  sequence s_settle;
    s_sel_cap ##1 clk_en;
  endsequence

  chk_old_queue_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE6
    s_sel_cap |=> (sel.act_queue == $past(sel.act_queue)) && (sel.act_sel == $past(sel.act_sel)))
    else $error("queue switched on the capture edge");

  chk_new_queue_two: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    s_settle |=> sel.act_queue == $past(addr_s[1:0], 2))
    else $error("new queue not active two edges after capture");

  chk_id_gate_sel: assert property (@(posedge clock) disable iff (!nrst) // RULE4
    s_settle |=> sel.act_sel == ($past(addr_dev, 2) == own_id_r))
    else $error("selection does not follow identity match");

  chk_no_strobe_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE5
    (!wstb_s && !$past(wstb_s)) |=> $stable(sel.act_queue))
    else $error("queue changed without address strobe");

  chk_write_target: assert property (@(posedge clock) disable iff (!nrst) // RULE2
    (clk_en && wr_go) |=> queue_write == queue_onehot($past(sel.act_queue)))
    else $error("write went to the wrong queue");

  chk_deselect_write: assert property (@(posedge clock) disable iff (!nrst) // RULE14
    (clk_en && !sel.act_sel) |=> queue_write == '0)
    else $error("write stored while deselected");

  chk_enable_gate: assert property (@(posedge clock) disable iff (!nrst) // RULE13
    (clk_en && wen_n_s) |=> queue_write == '0)
    else $error("write stored without enable");

  chk_flag_capture: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    (clk_en && fstb_s) |=> (flag_device_sel == $past(addr_s[4:2]))
      && (almost_full_flag_bus_oe == ($past(addr_s[4:2]) == own_id_r)))
    else $error("flag device not captured");

  chk_flag_with_write: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    (clk_en && fstb_s && wr_go) |=> queue_write != '0)
    else $error("write lost during flag strobe");

  chk_flag_bus_follow: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    ($past(clk_en) && almost_full_flag_bus_oe)
      |-> almost_full_flag_bus_o == $past(queue_almost_full))
    else $error("flag bus does not carry local status");
endmodule : wqas_write_addr_select
`default_nettype wire

// File: wqas_ctl_model.sv
// Behavioural write-side controller driving queue and flag-bus selections
`timescale 1ns/10ps
`default_nettype none
`include "wqas_regs.svh"
module wqas_ctl_model
(
  input  wire logic                    clock,
  input  wire logic                    serial_prog_done_out_n,
  output logic     [`WQAS_ADDR_W-1:0]  write_queue_addr,
  output logic                         write_addr_strobe,
  output logic                         flag_device_strobe,
  output logic                         write_en_n
);
  initial
  begin
    write_queue_addr   = 5'h00;
    write_addr_strobe  = 1'b0;
    flag_device_strobe = 1'b0;
    write_en_n         = 1'b1;
  end

  // One strobe cycle, with nw enabled writes starting on the same edge
  task automatic op(input logic [4:0] a, input logic qs, input logic fs, input int nw);
    int wait_cnt;
    wait_cnt = 0;
    while ((serial_prog_done_out_n !== 1'b0) && (wait_cnt < 64))
    begin
      @(negedge clock);
      wait_cnt++;
    end
    write_queue_addr   = a;
    write_addr_strobe  = qs;
    flag_device_strobe = fs & ~qs;
    write_en_n         = (nw == 0);
    @(negedge clock);
    write_addr_strobe  = 1'b0;
    flag_device_strobe = 1'b0;
    // Released address is not left showing the selection
    write_queue_addr   = ~a;
    if (nw > 1)
      repeat (nw - 1) @(negedge clock);
    write_en_n         = 1'b1;
  endtask : op
endmodule : wqas_ctl_model
`default_nettype wire

// File: wqas_write_addr_select_test.sv
// Self-checking bench for the write-queue address select block
`timescale 1ns/10ps
`default_nettype none
`include "wqas_regs.svh"
module wqas_write_addr_select_test;
  localparam logic [2:0] OWN_ID = 3'h5;
  typedef struct packed
  {
    logic       qs;
    logic [4:0] addr;
    logic [1:0] exp_q;
    logic       exp_sel;
  } wqas_row_t;
  logic       clock, nrst, clk_en, serial_prog_done_out_n;
  logic       write_addr_strobe, flag_device_strobe, write_en_n;
  logic       write_port_selected, almost_full_flag_bus_oe;
  logic [4:0] write_queue_addr;
  logic [3:0] queue_almost_full, queue_write, almost_full_flag_bus_o;
  logic [2:0] device_id, flag_device_sel;
  logic [1:0] active_queue;
  int         errors, num_checks;
  wqas_row_t  rows [8];

  wqas_write_addr_select dut (.clock, .nrst, .clk_en, .write_queue_addr, .write_addr_strobe,
    .flag_device_strobe, .write_en_n, .device_id, .queue_almost_full, .queue_write,
    .active_queue, .write_port_selected, .flag_device_sel, .almost_full_flag_bus_o,
    .almost_full_flag_bus_oe);
  wqas_ctl_model ctl (.clock, .serial_prog_done_out_n, .write_queue_addr,
    .write_addr_strobe, .flag_device_strobe, .write_en_n);

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if ((errors == 0) && (num_checks > 0))
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Flag-bus device selection with a write on the strobe edge
  task automatic fchk(input logic [4:0] a, input logic [3:0] st);
    logic       drv;
    logic [1:0] q_old;
    drv = (a[4:2] == OWN_ID);
    q_old = active_queue;
    queue_almost_full = st;
    @(negedge clock);
    ctl.op(a, 1'b0, 1'b1, 1);
    repeat (2) @(negedge clock);
    chk("flag dev", {1'b0, a[4:2]}, {1'b0, flag_device_sel});
    chk("flag oe", {3'h0, drv}, {3'h0, almost_full_flag_bus_oe});
    chk("flag bus", drv ? st : 4'h0, almost_full_flag_bus_o);
    chk("flag write", 4'h1 << q_old, queue_write);
    chk("flag queue", {2'h0, q_old}, {2'h0, active_queue});
  endtask : fchk

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    #50000;
    errors++;
    $display("mismatch watchdog expected done seen timeout");
    test_done();
  end

  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    device_id = OWN_ID;
    queue_almost_full = 4'hA;
    serial_prog_done_out_n = 1'b1;
    errors = 0;
    num_checks = 0;
    rows = '{'{1'b1, 5'h14, 2'h0, 1'b1}, '{1'b1, 5'h15, 2'h1, 1'b1},
             '{1'b0, 5'h16, 2'h1, 1'b1}, '{1'b1, 5'h16, 2'h2, 1'b1},
             '{1'b1, 5'h17, 2'h3, 1'b1}, '{1'b1, 5'h0B, 2'h3, 1'b0},
             '{1'b1, 5'h1C, 2'h0, 1'b0}, '{1'b1, 5'h17, 2'h3, 1'b1}};
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    serial_prog_done_out_n = 1'b0;
    foreach (rows[i])
    begin
      @(negedge clock);
      ctl.op(rows[i].addr, rows[i].qs, 1'b0, 0);
      repeat (3) @(negedge clock);
      chk("selected", {3'h0, rows[i].exp_sel}, {3'h0, write_port_selected});
      if (rows[i].exp_sel)
        chk("queue", {2'h0, rows[i].exp_q}, {2'h0, active_queue});
      ctl.op(5'h00, 1'b0, 1'b0, 1);
      repeat (2) @(negedge clock);
      chk("write", rows[i].exp_sel ? 4'h1 << rows[i].exp_q : 4'h0, queue_write);
      @(negedge clock);
      chk("write end", 4'h0, queue_write);
    end
    @(negedge clock);
    fork
      ctl.op(5'h15, 1'b1, 1'b0, 4);
      begin
        repeat (3) @(negedge clock);
        chk("old queue 0", 4'h8, queue_write);
        @(negedge clock);
        chk("old queue 1", 4'h8, queue_write);
        @(negedge clock);
        chk("new queue 2", 4'h2, queue_write);
        @(negedge clock);
        chk("new queue 3", 4'h2, queue_write);
      end
    join
    fchk(5'h17, 4'hA);
    fchk(5'h0E, 4'h5);
    // Clock enable low freezes selection and outputs
    clk_en = 1'b0;
    ctl.op(5'h14, 1'b1, 1'b0, 1);
    repeat (3) @(negedge clock);
    chk("frozen queue", 4'h5, {1'b0, write_port_selected, active_queue});
    chk("frozen write", 4'h2, queue_write);
    clk_en = 1'b1;
    // Mid-run reset clears everything without a clock edge
    @(negedge clock);
    nrst = 1'b0;
    serial_prog_done_out_n = 1'b1;
    #5;
    chk("reset ctl", 4'h0, {write_port_selected, almost_full_flag_bus_oe, active_queue});
    chk("reset dev", 4'h0, {1'b0, flag_device_sel});
    chk("reset bus", 4'h0, almost_full_flag_bus_o);
    chk("reset write", 4'h0, queue_write);
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    serial_prog_done_out_n = 1'b0;
    ctl.op(5'h00, 1'b0, 1'b0, 1);
    repeat (2) @(negedge clock);
    chk("write unselected", 4'h0, queue_write);
    ctl.op(5'h16, 1'b1, 1'b0, 0);
    repeat (3) @(negedge clock);
    chk("queue after reset", 4'h6, {1'b0, write_port_selected, active_queue});
    test_done();
  end
endmodule : wqas_write_addr_select_test
`default_nettype wire
